// *** limit_guard.sv ***
// Contract
// (R01) limit inputs ignored by default; act only for selection 0 or 2
// (R02) input terminal mapping and polarity reassignable by software
// (R03) stop selection picks dynamic brake, free run or immediate stop; counter cleared
// (R04) stop 0/1: zero torque toward prohibited side, counter held after stop
// (R05) stop 2: normal torque after stop; counter cleared at end, then held
// (R06) selection 2: either input open raises error 38; fault reaction governs
// (R07) fault reaction option overrides limit stop selection for any error
// (R08) deceleration ends at 30 r/min or below; post-stop behaviour then
// (R09) immediate stop keeps servo on, closed loop, torque capped by stop torque
// (R10) stop torque 0..500% in 0.1% steps; zero selects normal limit
// (R11) immediate stop raises error 24 when error exceeds following window
// (R12) warning B1 on command toward open limit while stopped
// (R13) open forward limit blocks forward only; open reverse blocks reverse only
// (R14) overrun error 34 and stop when position leaves the allowed band
// (R15) overrun check only in position or fully-closed mode with servo on
// (R16) range cleared at power-up and whenever position error is cleared
// (R17) range cleared at trial start/end and position data initialisation
// (R18) on overrun, stop follows fault reaction option
// (R19) overrun check suspended during frequency-response analysis
// (R20) with no command the band is the overrun limit each side of hold
// (R21) with commands the band covers all commanded travel plus limit each end
// (R22) selection 0: both inputs open raises error 38
// (R23) conditions evaluated and acted on in every control cycle
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "limit_guard_regs.svh"

module limit_guard
    import limit_guard_pkg::*;
#(
    parameter int POS_W  = 32,
    parameter int SPD_W  = 16,
    parameter int TRQ_W  = 13
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             limit_pin_a,
    input  wire logic             limit_pin_b,
    input  wire logic [SPD_W-1:0] speed_abs_rpm,
    input  wire logic             cmd_valid,
    input  wire logic             cmd_dir_fwd,
    input  wire logic [POS_W-1:0] cmd_position,
    input  wire logic [POS_W-1:0] act_position,
    input  wire logic [POS_W-1:0] pos_error_abs,
    input  wire logic [TRQ_W-1:0] normal_torque_limit,
    output logic                  brake_dynamic,
    output logic                  drive_off,
    output logic                  servo_hold_on,
    output logic                  block_fwd,
    output logic                  block_rev,
    output logic                  err_counter_clear,
    output logic                  err_counter_hold,
    output logic      [TRQ_W-1:0] torque_limit,
    output logic                  fault_reaction,
    output logic                  err38,
    output logic                  err24,
    output logic                  err34,
    output logic                  warn_b1
);
    // configuration and event registers
    logic [1:0]       limit_sel_reg;
    logic [1:0]       stop_sel_reg;
    logic [TRQ_W-1:0] stop_torque_reg;
    logic [POS_W-1:0] overrun_lim_reg;
    logic [POS_W-1:0] follow_win_reg;
    logic [3:0]       input_map_reg;
    logic [6:0]       control_reg;
    logic [3:0]       event_reg;
    logic [3:0]       event_next;
    logic             ctl_pulse_reg;
    logic             pin_a_s1_reg, pin_a_s2_reg, pin_b_s1_reg, pin_b_s2_reg;
    guard_state_e     state_reg;
    guard_state_e     state_next;
    logic [POS_W-1:0] range_min_reg, range_max_reg;
    logic             range_valid_reg;

    function automatic logic [POS_W-1:0] sat_add(input logic [POS_W-1:0] a,
                                                 input logic [POS_W-1:0] b);
        logic [POS_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[POS_W] ? {POS_W{1'b1}} : s[POS_W-1:0];
    endfunction

    function automatic logic [POS_W-1:0] sat_sub(input logic [POS_W-1:0] a,
                                                 input logic [POS_W-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction

    // apb decode
    wire       acc     = psel & penable;
    wire       wr_en   = acc & pwrite & clk_en;
    wire       hit_ls  = paddr == `OFS_LIMIT_SEL;
    wire       hit_ss  = paddr == `OFS_STOP_SEL;
    wire       hit_st  = paddr == `OFS_STOP_TORQUE;
    wire       hit_ol  = paddr == `OFS_OVERRUN_LIM;
    wire       hit_fw  = paddr == `OFS_FOLLOW_WIN;
    wire       hit_im  = paddr == `OFS_INPUT_MAP;
    wire       hit_ct  = paddr == `OFS_CONTROL;
    wire       hit_sr  = paddr == `OFS_STATUS;
    wire       hit_ev  = paddr == `OFS_EVENT;
    wire       mapped  = hit_ls | hit_ss | hit_st | hit_ol | hit_fw | hit_im | hit_ct
                         | hit_sr | hit_ev;
    // torque above 500.0% is refused as a slave error rather than clipped silently
    wire       bad_trq = hit_st & pwrite & (pwdata[TRQ_W-1:0] > `STOP_TORQUE_MAX
                                           || pwdata[31:TRQ_W] != '0);
    wire       wr_ok   = wr_en & ~bad_trq & pstrb[0];

    assign pready  = 1'b1;
    assign pslverr = acc & (~mapped | bad_trq);

    // limit pins come from switches: two-stage synchroniser each
    // reset to the closed level so no false open is seen just after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_s1_reg <= 1'b1;
            pin_a_s2_reg <= 1'b1;
            pin_b_s1_reg <= 1'b1;
            pin_b_s2_reg <= 1'b1;
        end else if (clk_en) begin
            pin_a_s1_reg <= limit_pin_a;
            pin_a_s2_reg <= pin_a_s1_reg;
            pin_b_s1_reg <= limit_pin_b;
            pin_b_s2_reg <= pin_b_s1_reg;
        end
    end

    // terminal allocation and logic; a pin high means closed (normal) unless inverted
    wire fwd_raw   = input_map_reg[`MAP_FWD_SWAP] ? pin_b_s2_reg : pin_a_s2_reg; // R02
    wire rev_raw   = input_map_reg[`MAP_FWD_SWAP] ? pin_a_s2_reg : pin_b_s2_reg; // R02
    wire forward_limit_input = fwd_raw ^ input_map_reg[`MAP_FWD_INV];            // R02
    wire reverse_limit_input = rev_raw ^ input_map_reg[`MAP_REV_INV];            // R02
    wire lim_en    = (limit_sel_reg == 2'd0) | (limit_sel_reg == 2'd2);          // R01
    wire fwd_open  = lim_en & ~forward_limit_input;                              // R01
    wire rev_open  = lim_en & ~reverse_limit_input;                              // R01

    // control bits and derived conditions
    wire servo_on  = control_reg[`CTL_SERVO_ON];
    wire pos_mode  = control_reg[`CTL_POS_MODE] | control_reg[`CTL_FULL_CLOSED];
    wire stopped   = speed_abs_rpm <= SPD_W'(`STOP_SPEED_RPM);                   // R08
    wire any_err   = |event_reg[`EVT_ERR34:`EVT_ERR38];
    wire err38_set = (limit_sel_reg == 2'd2 & (fwd_open | rev_open))             // R06
                   | (limit_sel_reg == 2'd0 & fwd_open & rev_open);              // R22
    wire trip      = (fwd_open | rev_open) & ~err38_set;
    wire toward_open = cmd_valid & ((cmd_dir_fwd & fwd_open) | (~cmd_dir_fwd & rev_open));
    wire decel     = state_reg == ST_DECEL;
    wire imm       = stop_sel_reg == STOP_IMMEDIATE;
    wire err24_set = decel & imm & (pos_error_abs > follow_win_reg);             // R11
    wire b1_set    = stopped & toward_open;                                      // R12

    // stop sequencer, evaluated every enabled cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:     if (any_err) state_next = ST_FAULT;                      // R07
                        else if (trip) state_next = stopped ? ST_STOPPED : ST_DECEL; // R23
            ST_DECEL:   if (any_err) state_next = ST_FAULT;                      // R07
                        else if (stopped) state_next = ST_STOPPED;               // R08
            ST_STOPPED: if (any_err) state_next = ST_FAULT;
                        else if (!trip) state_next = ST_RUN;
            ST_FAULT:   if (!any_err) state_next = ST_RUN;
            default:    state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_reg <= ST_RUN;
        else if (clk_en) state_reg <= state_next;
    end

    // deceleration outputs; fault state hands the stop to the fault reaction
    // every stop method clears the counter for the whole deceleration,
    // its last cycle included, and the stopped state holds it afterwards
    wire ctr_clr   = decel | ~servo_on                                          // R03 R05
                   | control_reg[`CTL_CLR_ERR];
    wire [TRQ_W-1:0] stop_trq = (stop_torque_reg == '0) ? normal_torque_limit   // R10
                              : stop_torque_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_dynamic     <= 1'b0;
            drive_off         <= 1'b0;
            servo_hold_on     <= 1'b0;
            block_fwd         <= 1'b0;
            block_rev         <= 1'b0;
            err_counter_clear <= 1'b0;
            err_counter_hold  <= 1'b0;
            torque_limit      <= '0;
            fault_reaction    <= 1'b0;
        end else if (clk_en) begin
            brake_dynamic     <= decel & stop_sel_reg == STOP_DYN_BRAKE;         // R03
            drive_off         <= decel & stop_sel_reg == STOP_FREE_RUN;          // R03
            servo_hold_on     <= decel & imm;                                    // R09
            block_fwd         <= fwd_open;                                       // R13 R04
            block_rev         <= rev_open;                                       // R13 R04
            err_counter_clear <= ctr_clr;                                        // R03
            err_counter_hold  <= state_reg == ST_STOPPED;                        // R04 R05
            torque_limit      <= (decel & imm) ? stop_trq : normal_torque_limit; // R09 R05
            fault_reaction    <= state_next == ST_FAULT;                         // R07 R18
        end
    end

    // commanded range tracker and overrun check
    wire range_clr = ~servo_on | ctr_clr | control_reg[`CTL_TRIAL]               // R16 R17
                   | control_reg[`CTL_POS_INIT];                                 // R17
    wire [POS_W-1:0] lo_pos  = range_valid_reg ? range_min_reg : cmd_position;
    wire [POS_W-1:0] hi_pos  = range_valid_reg ? range_max_reg : cmd_position;
    wire [POS_W-1:0] band_lo = sat_sub(lo_pos, overrun_lim_reg);                 // R20 R21
    wire [POS_W-1:0] band_hi = sat_add(hi_pos, overrun_lim_reg);                 // R20 R21
    wire chk_on    = pos_mode & servo_on & ~control_reg[`CTL_FFT];               // R15 R19
    wire err34_set = chk_on & (act_position < band_lo | act_position > band_hi); // R14

    // range widens with each command; a trial toggle is held as a clear level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_valid_reg <= 1'b0;                                             // R16
            range_min_reg   <= '0;
            range_max_reg   <= '0;
        end else if (clk_en) begin
            if (range_clr) begin
                range_valid_reg <= 1'b0;                                         // R16
                range_min_reg   <= '0;
                range_max_reg   <= '0;
            end else begin
                range_valid_reg <= 1'b1;
                range_min_reg   <= (cmd_position < lo_pos) ? cmd_position : lo_pos; // R21
                range_max_reg   <= (cmd_position > hi_pos) ? cmd_position : hi_pos; // R21
            end
        end
    end

    // sticky events: set wins over a write-one-to-clear in the same cycle
    wire [3:0] ev_set = {b1_set, err34_set, err24_set, err38_set};
    wire [3:0] ev_clr = (wr_ok & hit_ev) ? pwdata[3:0] : 4'h0;
    assign event_next = (event_reg & ~ev_clr) | ev_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) event_reg <= 4'h0;
        else if (clk_en) event_reg <= event_next;                                // R23
    end

    assign err38 = event_reg[`EVT_ERR38];
    assign err24 = event_reg[`EVT_ERR24];
    assign err34 = event_reg[`EVT_ERR34];
    assign warn_b1 = event_reg[`EVT_WARN_B1];

    // register writes; clr and init bits self-clear after one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_sel_reg   <= `RST_LIMIT_SEL;
            stop_sel_reg    <= `RST_STOP_SEL;
            stop_torque_reg <= `RST_STOP_TORQUE;
            overrun_lim_reg <= `RST_OVERRUN_LIM;
            follow_win_reg  <= `RST_FOLLOW_WIN;
            input_map_reg   <= `RST_INPUT_MAP;
            control_reg     <= 7'h00;
            ctl_pulse_reg   <= 1'b0;
        end else if (clk_en) begin
            ctl_pulse_reg <= 1'b0;
            if (ctl_pulse_reg) begin
                control_reg[`CTL_POS_INIT] <= 1'b0;
                control_reg[`CTL_CLR_ERR]  <= 1'b0;
            end
            if (wr_ok) begin
                if (hit_ls) limit_sel_reg   <= pwdata[1:0];
                if (hit_ss) stop_sel_reg    <= pwdata[1:0];
                if (hit_st) stop_torque_reg <= pwdata[TRQ_W-1:0];
                if (hit_ol) overrun_lim_reg <= pwdata[POS_W-1:0];
                if (hit_fw) follow_win_reg  <= pwdata[POS_W-1:0];
                if (hit_im) input_map_reg   <= pwdata[3:0];
                if (hit_ct) begin
                    control_reg   <= pwdata[6:0];
                    ctl_pulse_reg <= 1'b1;
                end
            end
        end
    end

    // read mux
    wire [31:0] status_word = {24'h0, 1'b0, 2'(state_reg), stopped,
                               range_valid_reg, chk_on, fwd_open, rev_open};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (clk_en & psel & ~penable & ~pwrite) begin
            prdata <= ({32{hit_ls}} & {30'h0, limit_sel_reg})
                    | ({32{hit_ss}} & {30'h0, stop_sel_reg})
                    | ({32{hit_st}} & {19'h0, stop_torque_reg})
                    | ({32{hit_ol}} & overrun_lim_reg)
                    | ({32{hit_fw}} & follow_win_reg)
                    | ({32{hit_im}} & {28'h0, input_map_reg})
                    | ({32{hit_ct}} & {25'h0, control_reg})
                    | ({32{hit_sr}} & status_word)
                    | ({32{hit_ev}} & {28'h0, event_reg});
        end
    end

    // checks
    a_err38_both: assert property (@(posedge pclk) disable iff (!presetn) // R22
        clk_en && limit_sel_reg == 2'd0 && fwd_open && rev_open |=> err38)
        else $error("both limits open without error 38");
    a_err38_any: assert property (@(posedge pclk) disable iff (!presetn) // R06
        clk_en && limit_sel_reg == 2'd2 && (fwd_open || rev_open) |=> err38)
        else $error("limit open under selection 2 without error 38");
    a_ignore_sel1: assert property (@(posedge pclk) disable iff (!presetn) // R01
        limit_sel_reg == 2'd1 |-> !fwd_open && !rev_open)
        else $error("limit acted on while disabled");
    a_block_dir: assert property (@(posedge pclk) disable iff (!presetn) // R13
        clk_en && fwd_open && !rev_open |=> block_fwd && !block_rev)
        else $error("wrong direction blocked");
    a_decel_end: assert property (@(posedge pclk) disable iff (!presetn) // R08
        clk_en && decel && stopped && !any_err |=> state_reg == ST_STOPPED)
        else $error("deceleration did not end at low speed");
    a_imm_torque: assert property (@(posedge pclk) disable iff (!presetn) // R09
        clk_en && decel && imm && stop_torque_reg != '0 |=> torque_limit == $past(stop_torque_reg))
        else $error("immediate stop torque not applied");
    a_overrun_hit: assert property (@(posedge pclk) disable iff (!presetn) // R14
        clk_en && err34_set |=> err34)
        else $error("overrun not flagged");
    a_overrun_gate: assert property (@(posedge pclk) disable iff (!presetn) // R15 R19
        clk_en && !err34 && (!servo_on || control_reg[`CTL_FFT]) |=> !err34)
        else $error("overrun checked while disabled");
    a_range_clear: assert property (@(posedge pclk) disable iff (!presetn) // R16
        clk_en && !servo_on |=> !range_valid_reg && range_max_reg == '0)
        else $error("range not cleared at servo off");
    a_warn_b1: assert property (@(posedge pclk) disable iff (!presetn) // R12
        clk_en && stopped && toward_open |=> warn_b1)
        else $error("command warning missing");
endmodule

// *** limit_guard_pkg.sv ***
package limit_guard_pkg;
    typedef enum logic [1:0] {
        STOP_DYN_BRAKE,
        STOP_FREE_RUN,
        STOP_IMMEDIATE,
        STOP_RSVD
    } stop_method_e;

    typedef enum {
        ST_RUN,
        ST_DECEL,
        ST_STOPPED,
        ST_FAULT
    } guard_state_e;
endpackage

// *** limit_guard_regs.svh ***
`ifndef LIMIT_GUARD_REGS_SVH
`define LIMIT_GUARD_REGS_SVH
// register byte offsets
`define OFS_LIMIT_SEL     12'h000
`define OFS_STOP_SEL      12'h004
`define OFS_STOP_TORQUE   12'h008
`define OFS_OVERRUN_LIM   12'h00c
`define OFS_FOLLOW_WIN    12'h010
`define OFS_INPUT_MAP     12'h014
`define OFS_CONTROL       12'h018
`define OFS_STATUS        12'h01c
`define OFS_EVENT         12'h020
// reset values
`define RST_LIMIT_SEL     2'h1
`define RST_STOP_SEL      2'h0
`define RST_STOP_TORQUE   13'h0000
`define RST_OVERRUN_LIM   32'h0000_0000
`define RST_FOLLOW_WIN    32'h0000_0000
`define RST_INPUT_MAP     4'h0
// control register bit positions
`define CTL_SERVO_ON      0
`define CTL_POS_MODE      1
`define CTL_FULL_CLOSED   2
`define CTL_TRIAL         3
`define CTL_FFT           4
`define CTL_POS_INIT      5
`define CTL_CLR_ERR       6
// input map bit positions
`define MAP_FWD_SWAP      0
`define MAP_FWD_INV       1
`define MAP_REV_INV       2
// event bit positions
`define EVT_ERR38         0
`define EVT_ERR24         1
`define EVT_ERR34         2
`define EVT_WARN_B1       3
// torque and speed limits
`define STOP_TORQUE_MAX   13'd5000
`define STOP_SPEED_RPM    30
`endif

// *** limit_guard_tb.sv ***
`timescale 1ns/1ps
`include "limit_guard_regs.svh"
module limit_guard_tb;
    import limit_guard_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, act_position = 32'h0, cmd_position = 32'h0;
    logic pready, pslverr, limit_pin_a, limit_pin_b, cmd_valid = 1'b0, cmd_dir_fwd = 1'b0;
    logic fwd_open = 1'b0, rev_open = 1'b0, spd_load = 1'b0;
    logic [15:0] spd_set = 16'd200, speed_abs_rpm;
    logic [12:0] torque_limit;
    logic brake_dynamic, drive_off, servo_hold_on, block_fwd, block_rev, err_counter_clear;
    logic err_counter_hold, fault_reaction, err38, err24, err34, warn_b1;
    logic [11:0] obs;
    int err_total = 0, comparisons = 0;
    always #2.5 pclk = ~pclk;
    // one vector so a single wait task serves every flag
    assign obs = {warn_b1, err34, err24, err38, fault_reaction, err_counter_hold,
                  err_counter_clear, block_rev, block_fwd, servo_hold_on, drive_off, brake_dynamic};
    limit_guard uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .limit_pin_a(limit_pin_a), .limit_pin_b(limit_pin_b),
        .speed_abs_rpm(speed_abs_rpm), .cmd_valid(cmd_valid), .cmd_dir_fwd(cmd_dir_fwd),
        .cmd_position(cmd_position), .act_position(act_position), .pos_error_abs(32'h0000_0010),
        .normal_torque_limit(13'd3000), .brake_dynamic(brake_dynamic), .drive_off(drive_off),
        .servo_hold_on(servo_hold_on), .block_fwd(block_fwd), .block_rev(block_rev),
        .err_counter_clear(err_counter_clear), .err_counter_hold(err_counter_hold),
        .torque_limit(torque_limit), .fault_reaction(fault_reaction), .err38(err38),
        .err24(err24), .err34(err34), .warn_b1(warn_b1));
    limit_partner far (.pclk(pclk), .presetn(presetn), .fwd_open(fwd_open), .rev_open(rev_open),
        .spd_load(spd_load), .spd_set(spd_set), .brake_dynamic(brake_dynamic),
        .drive_off(drive_off), .servo_hold_on(servo_hold_on), .limit_pin_a(limit_pin_a),
        .limit_pin_b(limit_pin_b), .speed_abs_rpm(speed_abs_rpm));
    task finish_test;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait on one flag, then judge it
    task wt(input int i, input logic v, input int n);
        int k;
        k = 0;
        while (obs[i] !== v && k < n) begin
            @(negedge pclk);
            k++;
        end
        chk({31'h0, obs[i]}, {31'h0, v});
    endtask
    task hold(input int i, input logic v, input int n);
        repeat (n) begin
            @(negedge pclk);
            chk({31'h0, obs[i]}, {31'h0, v});
        end
    endtask
    // apb: request held until pready is seen high, released after that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        s = pslverr;
        if (n >= 20) begin
            err_total++;
            finish_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic s;
        apb(1'b1, a, d, r, s);
        chk({31'h0, s}, {31'h0, ee});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic s;
        apb(1'b0, a, 32'h0, r, s);
        chk(r, e);
        chk({31'h0, s}, {31'h0, ee});
    endtask
    task t_regs;
        rd(`OFS_LIMIT_SEL, 32'h1, 1'b0);
        rd(`OFS_STOP_SEL, 32'h0, 1'b0);
        rd(12'h040, 32'h0, 1'b1);
        wr(`OFS_STOP_TORQUE, 32'd5001, 1'b1);
        rd(`OFS_STOP_TORQUE, 32'h0, 1'b0);
        chk({19'h0, torque_limit}, {19'h0, 13'd3000});
        @(posedge pclk);
        fwd_open <= 1'b1;
        hold(3, 1'b0, 8);
        @(posedge pclk);
        fwd_open <= 1'b0;
        $display("test regs done");
    endtask
    task t_stop(input int m);
        wr(`OFS_CONTROL, 32'h1, 1'b0);
        wr(`OFS_LIMIT_SEL, 32'h0, 1'b0);
        wr(`OFS_STOP_SEL, m, 1'b0);
        wr(`OFS_STOP_TORQUE, 32'd1200, 1'b0);
        wr(`OFS_FOLLOW_WIN, 32'h20, 1'b0);
        @(posedge pclk);
        spd_load <= 1'b1;
        @(posedge pclk);
        spd_load <= 1'b0;
        fwd_open <= 1'b1;
        wt(m, 1'b1, 10);
        wt(5, 1'b1, 4);
        if (m == 2) chk({19'h0, torque_limit}, {19'h0, 13'd1200});
        wt(6, 1'b1, 60);
        wt(3, 1'b1, 4);
        hold(4, 1'b0, 1);
        if (m == 2) chk({19'h0, torque_limit}, {19'h0, 13'd3000});
        @(posedge pclk);
        cmd_dir_fwd <= 1'b1;
        cmd_valid <= 1'b1;
        wt(11, 1'b1, 8);
        @(posedge pclk);
        cmd_valid <= 1'b0;
        fwd_open <= 1'b0;
        wt(3, 1'b0, 8);
        wr(`OFS_EVENT, 32'hf, 1'b0);
        wt(11, 1'b0, 4);
        $display("test stop %0d done", m);
    endtask
    task t_err;
        wr(`OFS_FOLLOW_WIN, 32'h0, 1'b0);
        @(posedge pclk);
        spd_load <= 1'b1;
        fwd_open <= 1'b1;
        @(posedge pclk);
        spd_load <= 1'b0;
        wt(9, 1'b1, 10);
        wt(7, 1'b1, 4);
        @(posedge pclk);
        fwd_open <= 1'b0;
        wt(3, 1'b0, 8);
        wr(`OFS_EVENT, 32'hf, 1'b0);
        wr(`OFS_LIMIT_SEL, 32'h0, 1'b0);
        @(posedge pclk);
        fwd_open <= 1'b1;
        rev_open <= 1'b1;
        wt(8, 1'b1, 8);
        wt(7, 1'b1, 4);
        @(posedge pclk);
        fwd_open <= 1'b0;
        rev_open <= 1'b0;
        wt(3, 1'b0, 8);
        wr(`OFS_EVENT, 32'hf, 1'b0);
        wt(8, 1'b0, 6);
        wr(`OFS_LIMIT_SEL, 32'h2, 1'b0);
        @(posedge pclk);
        rev_open <= 1'b1;
        wt(8, 1'b1, 8);
        wt(7, 1'b1, 4);
        @(posedge pclk);
        rev_open <= 1'b0;
        wt(4, 1'b0, 8);
        wr(`OFS_EVENT, 32'hf, 1'b0);
        wt(7, 1'b0, 8);
        wr(`OFS_INPUT_MAP, 32'h2, 1'b0);
        wt(8, 1'b1, 8);
        wr(`OFS_INPUT_MAP, 32'h0, 1'b0);
        wt(3, 1'b0, 8);
        wr(`OFS_EVENT, 32'hf, 1'b0);
        wt(8, 1'b0, 6);
        wr(`OFS_LIMIT_SEL, 32'h1, 1'b0);
        $display("test errors done");
    endtask
    task t_ovr;
        wr(`OFS_OVERRUN_LIM, 32'd100, 1'b0);
        wr(`OFS_CONTROL, 32'h3, 1'b0);
        @(posedge pclk);
        act_position <= 32'd100;
        hold(10, 1'b0, 6);
        @(posedge pclk);
        act_position <= 32'd101;
        wt(10, 1'b1, 8);
        wt(7, 1'b1, 4);
        @(posedge pclk);
        act_position <= 32'd0;
        cmd_position <= 32'd1000;
        cmd_valid <= 1'b1;
        wr(`OFS_EVENT, 32'h4, 1'b0);
        cmd_valid <= 1'b0;
        act_position <= 32'd1100;
        hold(10, 1'b0, 6);
        @(posedge pclk);
        act_position <= 32'd1101;
        wt(10, 1'b1, 8);
        wr(`OFS_CONTROL, 32'h2, 1'b0);
        wr(`OFS_EVENT, 32'h4, 1'b0);
        act_position <= 32'd5000;
        hold(10, 1'b0, 6);
        wr(`OFS_CONTROL, 32'h13, 1'b0);
        hold(10, 1'b0, 6);
        wr(`OFS_CONTROL, 32'h3, 1'b0);
        wt(10, 1'b1, 8);
        $display("test overrun done");
    endtask
    // guard against a hang anywhere in the sequence
    initial begin
        #200000;
        err_total++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        for (int m = 0; m < 3; m++) t_stop(m);
        t_err;
        t_ovr;
        finish_test;
    end
endmodule

// *** limit_partner.sv ***
`timescale 1ns/1ps
// far side: two normally closed limit switches and a crude motor whose speed
// only falls while one of the guard's stop methods is acting on it
module limit_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fwd_open,
    input  wire logic        rev_open,
    input  wire logic        spd_load,
    input  wire logic [15:0] spd_set,
    input  wire logic        brake_dynamic,
    input  wire logic        drive_off,
    input  wire logic        servo_hold_on,
    output logic             limit_pin_a,
    output logic             limit_pin_b,
    output logic      [15:0] speed_abs_rpm
);
    // a high pin means the switch is closed and the axis is inside its travel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_pin_a   <= 1'b1;
            limit_pin_b   <= 1'b1;
            speed_abs_rpm <= 16'h0000;
        end else begin
            limit_pin_a <= !fwd_open;
            limit_pin_b <= !rev_open;
            if (spd_load) begin
                speed_abs_rpm <= spd_set;
            end else if ((brake_dynamic || drive_off || servo_hold_on) && speed_abs_rpm >= 16'd10) begin
                speed_abs_rpm <= speed_abs_rpm - 16'd10; // no coasting: slow only when told
            end
        end
    end
endmodule
